/* File: serial_debug_map.svh */
`ifndef SERIAL_DEBUG_MAP_SVH
`define SERIAL_DEBUG_MAP_SVH

// internal register select codes
`define SEL_HOLD_LAST 4'h3
`define SEL_ADDR_LAST 4'h7
`define SEL_COMMAND 4'h8
`define SEL_MODE 4'h9

// command codes
`define CMD_PORT_WR 4'h0
`define CMD_FLASH_PROG 4'h1
`define CMD_PORT_RD 4'h2
`define CMD_FLASH_RD 4'h3
`define CMD_ACC_RD 4'h4
`define CMD_PC_FLASH_RD 4'h5
`define CMD_PC_RD 4'h6
`define CMD_HALT 4'h7
`define CMD_START 4'h8
`define CMD_STEP 4'h9
`define CMD_PC_ZERO 4'hA
`define CMD_RESET_MOD 4'hB
`define CMD_NOP 4'hC
`define CMD_PAGE_ERASE 4'hD
`define CMD_PART_ERASE 4'hE
`define CMD_AUX_SEL 4'hF

// interface mode values
`define MODE_FOUR_WIRE 4'h0
`define MODE_THREE_WIRE 4'h1

// field positions and reset values
`define PAGE_LSB 6
`define FLASH_ADDR_MSB 11
`define HOLD_RESET 16'h0000
`define ADDR_RESET 16'h0000
`define NIBBLE_RESET 4'h0

`endif

/* File: serial_debug_pkg.sv */
package serial_debug_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PORT_WR = 3'b001,
        ST_PORT_RD = 3'b010,
        ST_PORT_TAKE = 3'b011,
        ST_FLASH = 3'b100
    } state_type;

    typedef enum logic [1:0] {
        FL_READ = 2'b00,
        FL_PROGRAM = 2'b01,
        FL_PAGE_ERASE = 2'b10,
        FL_PART_ERASE = 2'b11
    } flash_op_type;

    typedef struct packed {
        logic [3:0] select;
        logic [3:0] nibble;
    } nibble_write_type;

    typedef struct packed {
        logic req;
        flash_op_type op;
        logic aux;
        logic [11:0] addr;
        logic [7:0] wdata;
    } flash_req_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [3:0] sel;
        logic [15:0] wdata;
    } port_req_type;

    typedef struct packed {
        logic halt;
        logic step;
        logic pcClear;
        logic moduleReset;
    } cpu_ctrl_type;

    typedef struct packed {
        state_type state;
        logic [15:0] hold;
        logic [15:0] addr;
        logic [3:0] command;
        logic [3:0] mode;
        logic threeWire;
        logic aux;
        logic sync1;
        logic sync2;
        logic seen;
        logic ackToggle;
        logic [15:0] readback;
        flash_req_type flash;
        port_req_type port;
        cpu_ctrl_type ctrl;
    } core_state_type;

    typedef struct packed {
        logic toggle;
        nibble_write_type word;
        logic ackSync1;
        logic ackSync2;
        logic ackSeen;
        logic [15:0] readData;
    } link_state_type;

endpackage : serial_debug_pkg

/* File: serial_debug_command_unit.sv */
// Summary of operation
// - selects 0-3 load holding register nibbles
// - selects 4-7 load address register nibbles
// - select 8 loads and runs command
// - select 9 loads mode; 10-15 ignored
// - command 0 writes holding to port
// - command 1 programs flash low byte
// - command 2 reads port into holding
// - command 3 reads flash into holding
// - command 4 copies accumulator to holding
// - command 5 reads flash at program counter
// - command 6 copies program counter
// - command 7 halts, 8 restarts
// - command 9 steps one cycle
// - command 10 clears program counter
// - command 11 pulses module reset
// - command 13 erases one flash page
// - command 14 erases selected partition
// - command 15 selects aux; halt restores
// - processor port access wins over host
// - mode 0 four-wire, 1 three-wire
`timescale 1ns/10ps
`default_nettype none
`include "serial_debug_map.svh"

module serial_debug_command_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic linkClk,
    input wire logic linkWrite,
    input wire logic [3:0] linkSelect,
    input wire logic [3:0] linkNibble,
    output logic linkReady,
    output logic [15:0] linkReadData,
    input wire logic cpuPortBusy,
    input wire logic [15:0] cpuPortRdata,
    input wire logic [15:0] cpuAcc,
    input wire logic [15:0] cpuPc,
    output serial_debug_pkg::port_req_type cpuPort,
    output serial_debug_pkg::cpu_ctrl_type cpuCtrl,
    input wire logic flashDone,
    input wire logic [7:0] flashRdata,
    output serial_debug_pkg::flash_req_type flashCmd,
    output logic threeWire
);
    import serial_debug_pkg::*;

    logic coreRst1;
    logic coreRstN;
    logic linkRst1;
    logic linkRstN;
    core_state_type core;
    core_state_type next_core;
    link_state_type link;
    link_state_type next_link;
    logic done;
    logic [3:0] sel;
    logic [3:0] nib;

    // reset released through two stages in each domain
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            coreRst1 <= 1'b0;
            coreRstN <= 1'b0;
        end else begin
            coreRst1 <= 1'b1;
            coreRstN <= coreRst1;
        end
    end

    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            linkRst1 <= 1'b0;
            linkRstN <= 1'b0;
        end else begin
            linkRst1 <= 1'b1;
            linkRstN <= linkRst1;
        end
    end

    // link side: one nibble in flight at a time; the word stays put
    // until the core acknowledges, so the core may read it directly
    always_comb begin
        next_link = link;
        next_link.ackSync1 = core.ackToggle;
        next_link.ackSync2 = link.ackSync1;
        if (link.ackSync2 != link.ackSeen) begin
            next_link.ackSeen = link.ackSync2;
            next_link.readData = core.readback;
        end
        if (linkWrite && (link.toggle == link.ackSeen)) begin
            next_link.word.select = linkSelect;
            next_link.word.nibble = linkNibble;
            next_link.toggle = ~link.toggle;
        end
    end

    always_ff @(posedge linkClk or negedge linkRstN) begin
        if (!linkRstN) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    assign linkReady = (link.toggle == link.ackSeen);
    assign linkReadData = link.readData;

    always_comb begin
        next_core = core;
        done = 1'b0;
        sel = link.word.select;
        nib = link.word.nibble;
        next_core.sync1 = link.toggle;
        next_core.sync2 = core.sync1;
        next_core.port.write = 1'b0;
        next_core.port.read = 1'b0;
        next_core.ctrl.step = 1'b0;
        next_core.ctrl.pcClear = 1'b0;
        next_core.ctrl.moduleReset = 1'b0;
        unique case (core.state)
            ST_IDLE: begin
                if (core.sync2 != core.seen) begin
                    next_core.seen = core.sync2;
                    done = 1'b1;
                    if (sel <= `SEL_HOLD_LAST) begin
                        next_core.hold[{sel[1:0], 2'b00} +: 4] = nib;
                    end else if (sel <= `SEL_ADDR_LAST) begin
                        next_core.addr[{sel[1:0], 2'b00} +: 4] = nib;
                    end else if (sel == `SEL_MODE) begin
                        next_core.mode = nib;
                        // unused mode codes fall back to four wires
                        next_core.threeWire =
                            (nib == `MODE_THREE_WIRE);
                    end else if (sel == `SEL_COMMAND) begin
                        next_core.command = nib;
                        next_core.flash.aux = core.aux;
                        next_core.flash.wdata = core.hold[7:0];
                        next_core.flash.addr =
                            core.addr[`FLASH_ADDR_MSB:0];
                        unique case (nib)
                            `CMD_PORT_WR: begin
                                next_core.state = ST_PORT_WR;
                                done = 1'b0;
                            end
                            `CMD_FLASH_PROG: begin
                                next_core.flash.req = 1'b1;
                                next_core.flash.op = FL_PROGRAM;
                                next_core.state = ST_FLASH;
                                done = 1'b0;
                            end
                            `CMD_PORT_RD: begin
                                next_core.state = ST_PORT_RD;
                                done = 1'b0;
                            end
                            `CMD_FLASH_RD: begin
                                next_core.flash.req = 1'b1;
                                next_core.flash.op = FL_READ;
                                next_core.state = ST_FLASH;
                                done = 1'b0;
                            end
                            `CMD_ACC_RD: begin
                                next_core.hold = cpuAcc;
                            end
                            `CMD_PC_FLASH_RD: begin
                                next_core.flash.req = 1'b1;
                                next_core.flash.op = FL_READ;
                                next_core.flash.addr =
                                    cpuPc[`FLASH_ADDR_MSB:0];
                                next_core.state = ST_FLASH;
                                done = 1'b0;
                            end
                            `CMD_PC_RD: begin
                                next_core.hold = cpuPc;
                            end
                            `CMD_HALT: begin
                                next_core.ctrl.halt = 1'b1;
                                next_core.aux = 1'b0;
                            end
                            `CMD_START: begin
                                next_core.ctrl.halt = 1'b0;
                            end
                            `CMD_STEP: begin
                                // halt stays set; one pulse lets one
                                // processor cycle through
                                next_core.ctrl.step = 1'b1;
                            end
                            `CMD_PC_ZERO: begin
                                next_core.ctrl.pcClear = 1'b1;
                            end
                            `CMD_RESET_MOD: begin
                                next_core.ctrl.moduleReset = 1'b1;
                            end
                            `CMD_NOP: begin
                            end
                            `CMD_PAGE_ERASE: begin
                                next_core.flash.req = 1'b1;
                                next_core.flash.op = FL_PAGE_ERASE;
                                next_core.flash.addr = {
                                    core.addr[`FLASH_ADDR_MSB:`PAGE_LSB],
                                    6'h00};
                                next_core.state = ST_FLASH;
                                done = 1'b0;
                            end
                            `CMD_PART_ERASE: begin
                                // size comes from the partition flag
                                next_core.flash.req = 1'b1;
                                next_core.flash.op = FL_PART_ERASE;
                                next_core.flash.addr = 12'h000;
                                next_core.state = ST_FLASH;
                                done = 1'b0;
                            end
                            `CMD_AUX_SEL: begin
                                next_core.aux = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ST_PORT_WR: begin
                // the processor owns the ports while it accesses them
                if (!cpuPortBusy) begin
                    next_core.port.write = 1'b1;
                    next_core.port.sel = core.addr[3:0];
                    next_core.port.wdata = core.hold;
                    next_core.state = ST_IDLE;
                    done = 1'b1;
                end
            end
            ST_PORT_RD: begin
                if (!cpuPortBusy) begin
                    next_core.port.read = 1'b1;
                    next_core.port.sel = core.addr[3:0];
                    next_core.state = ST_PORT_TAKE;
                end
            end
            ST_PORT_TAKE: begin
                next_core.hold = cpuPortRdata;
                next_core.state = ST_IDLE;
                done = 1'b1;
            end
            ST_FLASH: begin
                if (flashDone) begin
                    next_core.flash.req = 1'b0;
                    if (core.flash.op == FL_READ) begin
                        next_core.hold[7:0] = flashRdata;
                    end
                    next_core.state = ST_IDLE;
                    done = 1'b1;
                end
            end
            default: begin
                next_core.state = ST_IDLE;
            end
        endcase
        // acknowledge only when the nibble's work is finished
        if (done) begin
            next_core.readback = next_core.hold;
            next_core.ackToggle = ~core.ackToggle;
        end
    end

    always_ff @(posedge mclk or negedge coreRstN) begin
        if (!coreRstN) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    assign cpuPort = core.port;
    assign cpuCtrl = core.ctrl;
    assign flashCmd = core.flash;
    assign threeWire = core.threeWire;

endmodule : serial_debug_command_unit
`default_nettype wire

/* File: serial_debug_wrap_unused.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: serial_debug_command_unit_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_debug_command_unit_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cpuPortBusy,
    input wire logic flashDone,
    input wire serial_debug_pkg::port_req_type cpuPort,
    input wire serial_debug_pkg::cpu_ctrl_type cpuCtrl,
    input wire serial_debug_pkg::flash_req_type flashCmd
);
    import serial_debug_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_req_held: assert property (
        flashCmd.req && !flashDone |=> flashCmd.req)
        else $error("flash request dropped before done");
    chk_req_drop: assert property (
        flashDone |=> !flashCmd.req)
        else $error("flash request kept after done");
    chk_wr_pulse: assert property (cpuPort.write |=> !cpuPort.write)
        else $error("port write longer than one cycle");
    chk_rd_pulse: assert property (cpuPort.read |=> !cpuPort.read)
        else $error("port read longer than one cycle");
    chk_host_yields: assert property (
        $rose(cpuPort.write | cpuPort.read) |-> !$past(cpuPortBusy))
        else $error("host port access while processor busy");
    chk_step_pulse: assert property (cpuCtrl.step |=> !cpuCtrl.step)
        else $error("step longer than one cycle");
    chk_pc_pulse: assert property (cpuCtrl.pcClear |=> !cpuCtrl.pcClear)
        else $error("pc clear longer than one cycle");
    chk_mod_pulse: assert property (
        cpuCtrl.moduleReset |=> !cpuCtrl.moduleReset)
        else $error("module reset longer than one cycle");
    chk_page_align: assert property (
        flashCmd.req && flashCmd.op == FL_PAGE_ERASE
        |-> flashCmd.addr[5:0] == 6'h00)
        else $error("page erase address not page aligned");
    chk_part_addr: assert property (
        flashCmd.req && flashCmd.op == FL_PART_ERASE
        |-> flashCmd.addr == 12'h000)
        else $error("partition erase address not zero");
endmodule : serial_debug_command_unit_chk
bind serial_debug_command_unit serial_debug_command_unit_chk u_chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .cpuPortBusy(cpuPortBusy),
    .flashDone(flashDone),
    .cpuPort(cpuPort),
    .cpuCtrl(cpuCtrl),
    .flashCmd(flashCmd)
);
`default_nettype wire

/* File: serial_debug_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_debug_far_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire serial_debug_pkg::port_req_type cpuPort,
    input wire serial_debug_pkg::flash_req_type flashCmd,
    output logic cpuPortBusy,
    output logic [15:0] cpuPortRdata,
    output logic flashDone,
    output logic [7:0] flashRdata,
    output serial_debug_pkg::port_req_type lastPort,
    output serial_debug_pkg::flash_req_type lastFlash
);
    import serial_debug_pkg::*;
    logic [2:0] phase;
    logic [1:0] delay;
    logic served;
    // processor owns the ports three cycles in eight
    assign cpuPortBusy = phase < 3'h3;
    // valid only while the read strobe stands, which is the cycle the
    // unit latches it; outside it the data is inverted, never a match
    assign cpuPortRdata = cpuPort.read ? 16'h5A3C : 16'hA5C3;
    assign flashRdata = flashDone ? flashCmd.addr[7:0] ^ 8'hA5
        : ~(flashCmd.addr[7:0] ^ 8'hA5);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 3'h0;
            delay <= 2'h0;
            served <= 1'b0;
            flashDone <= 1'b0;
            lastPort <= '0;
            lastFlash <= '0;
        end else begin
            phase <= phase + 3'h1;
            flashDone <= 1'b0;
            if (cpuPort.write) begin
                lastPort <= cpuPort;
            end
            if (!flashCmd.req) begin
                served <= 1'b0;
                delay <= 2'h0;
            end else if (!served) begin
                if (delay == 2'h0) begin
                    lastFlash <= flashCmd;
                end
                delay <= delay + 2'h1;
                if (delay == 2'h3) begin
                    flashDone <= 1'b1;
                    served <= 1'b1;
                end
            end
        end
    end
endmodule : serial_debug_far_model
`default_nettype wire

/* File: serial_debug_command_unit_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
 $display("[ERR] %s exp %h got %h", nm, ex, got); num_errors++; end end
module serial_debug_command_unit_tb_top;
    import serial_debug_pkg::*;
    logic mclk = 1'b0;
    logic linkClk = 1'b0;
    logic rst_n = 1'b0;
    logic lkRun = 1'b1;
    logic linkWrite = 1'b0;
    logic [3:0] linkSelect = 4'h0;
    logic [3:0] linkNibble = 4'h0;
    logic [15:0] cpuAcc = 16'h1357;
    logic [15:0] cpuPc = 16'h0246;
    logic linkReady, cpuPortBusy, flashDone, threeWire;
    logic [15:0] linkReadData, cpuPortRdata;
    logic [7:0] flashRdata;
    port_req_type cpuPort, lastPort;
    cpu_ctrl_type cpuCtrl;
    flash_req_type flashCmd, lastFlash;
    logic [3:0] rdCmd [5] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h5};
    logic [15:0] rdExp [5] = '{16'h5A3C, 16'h5A19, 16'h1357, 16'h0246,
        16'h02E3};
    int num_errors = 0;
    int cmp_count = 0;
    int stepCnt = 0;
    int clrCnt = 0;
    int modCnt = 0;
    always #12.5 mclk = ~mclk;
    // count control pulses so a lost or doubled pulse shows up
    always @(posedge mclk) begin
        if (cpuCtrl.step === 1'b1) begin
            stepCnt <= stepCnt + 1;
        end
        if (cpuCtrl.pcClear === 1'b1) begin
            clrCnt <= clrCnt + 1;
        end
        if (cpuCtrl.moduleReset === 1'b1) begin
            modCnt <= modCnt + 1;
        end
    end
    // host clock parks low between writes
    always begin
        #32;
        if (lkRun || linkClk) linkClk = ~linkClk;
    end
    serial_debug_command_unit u_dut (.mclk(mclk), .rst_n(rst_n),
        .linkClk(linkClk), .linkWrite(linkWrite), .linkSelect(linkSelect),
        .linkNibble(linkNibble), .linkReady(linkReady),
        .linkReadData(linkReadData), .cpuPortBusy(cpuPortBusy),
        .cpuPortRdata(cpuPortRdata), .cpuAcc(cpuAcc), .cpuPc(cpuPc),
        .cpuPort(cpuPort), .cpuCtrl(cpuCtrl), .flashDone(flashDone),
        .flashRdata(flashRdata), .flashCmd(flashCmd), .threeWire(threeWire));
    serial_debug_far_model u_far (.mclk(mclk), .rst_n(rst_n),
        .cpuPort(cpuPort), .flashCmd(flashCmd), .cpuPortBusy(cpuPortBusy),
        .cpuPortRdata(cpuPortRdata), .flashDone(flashDone),
        .flashRdata(flashRdata), .lastPort(lastPort), .lastFlash(lastFlash));
    task automatic final_report;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [3:0] s, input logic [3:0] n);
        int i;
        lkRun = 1'b1;
        @(posedge linkClk);
        linkWrite <= 1'b1;
        linkSelect <= s;
        linkNibble <= n;
        @(posedge linkClk);
        linkWrite <= 1'b0;
        i = 0;
        do begin
            @(posedge linkClk);
            #1;
            i++;
        end while (linkReady !== 1'b1 && i < 200);
        if (i >= 200) begin
            num_errors++;
            final_report();
        end
        lkRun = 1'b0;
    endtask : wr
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge linkClk);
        for (int k = 0; k < 4; k++) wr(4'(k), 4'(k + 1));
        `CHK("hold", 16'h4321, linkReadData)
        wr(4'hA, 4'hF);
        `CHK("unused sel", 16'h4321, linkReadData)
        for (int k = 0; k < 4; k++) wr(4'(k + 4), 4'(16'h0ABC >> (4 * k)));
        wr(4'h8, 4'h0);
        `CHK("port sel", 4'hC, lastPort.sel)
        `CHK("port data", 16'h4321, lastPort.wdata)
        foreach (rdCmd[k]) begin
            wr(4'h8, rdCmd[k]);
            `CHK("readback", rdExp[k], linkReadData)
        end
        wr(4'h8, 4'hF);
        wr(4'h8, 4'h1);
        `CHK("prog aux", 1'b1, lastFlash.aux)
        `CHK("prog op", FL_PROGRAM, lastFlash.op)
        `CHK("prog addr", 12'hABC, lastFlash.addr)
        `CHK("prog data", 8'hE3, lastFlash.wdata)
        wr(4'h8, 4'hD);
        `CHK("page op", FL_PAGE_ERASE, lastFlash.op)
        `CHK("page addr", 12'hA80, lastFlash.addr)
        wr(4'h8, 4'hE);
        `CHK("part op", FL_PART_ERASE, lastFlash.op)
        `CHK("part aux", 1'b1, lastFlash.aux)
        wr(4'h8, 4'h7);
        `CHK("halt", 1'b1, cpuCtrl.halt)
        wr(4'h8, 4'h3);
        `CHK("main again", 1'b0, lastFlash.aux)
        for (int k = 9; k < 13; k++) wr(4'h8, 4'(k));
        `CHK("halt after step", 1'b1, cpuCtrl.halt)
        `CHK("step count", 1, stepCnt)
        `CHK("pc clear count", 1, clrCnt)
        `CHK("module reset count", 1, modCnt)
        wr(4'h8, 4'h8);
        `CHK("start", 1'b0, cpuCtrl.halt)
        wr(4'h9, 4'h1);
        `CHK("three wire", 1'b1, threeWire)
        wr(4'h9, 4'h0);
        `CHK("four wire", 1'b0, threeWire)
        final_report();
    end
endmodule : serial_debug_command_unit_tb_top
`default_nettype wire
